/* common/iomb_defines.vh */
// Operation
// - Increments add one to 7-bit addressed register.
// - Skip increment zero result squashes next instruction.
// - Destination bit 0 accumulator, 1 register.
// - Branch loads immediate plus page latch bits.
// - Branch takes two cycles, flags unchanged.
// - OR literal into accumulator, update zero.
// - OR accumulator with register, update zero.
// - Move register to destination, update zero.
`ifndef IOMB_DEFINES_VH
`define IOMB_DEFINES_VH

// ----------------------------------------------------------------
// Fourteen-bit opcode fields.
// ----------------------------------------------------------------
`define IOMB_OP_W 14
`define IOMB_TARGET_W 13
`define IOMB_FA_W 7
`define IOMB_DEST_BIT 7
`define IOMB_LIT_MSB 7
`define IOMB_BR_MSB 10
`define IOMB_PAGE_LO 3
`define IOMB_PAGE_HI 4

// Opcode match patterns, masked.
`define IOMB_BYTE_MASK 14'h3F00
`define IOMB_INCSKIP_PAT 14'h0F00
`define IOMB_INC_PAT 14'h0A00
`define IOMB_ORF_PAT 14'h0400
`define IOMB_MOVE_PAT 14'h0800
`define IOMB_IORL_MASK 14'h3F00
`define IOMB_IORL_PAT 14'h3800
`define IOMB_BR_MASK 14'h3800
`define IOMB_BR_PAT 14'h2800

// Decoded operation codes.
`define IOMB_K_NONE 3'h0
`define IOMB_K_INCSKIP 3'h1
`define IOMB_K_INC 3'h2
`define IOMB_K_IORL 3'h3
`define IOMB_K_IORF 3'h4
`define IOMB_K_MOVE 3'h5
`define IOMB_K_BRANCH 3'h6

`define IOMB_ACC_RST 8'h00
`define IOMB_TARGET_RST 13'h0000
`define IOMB_FA_RST 7'h00
`define IOMB_ZERO_FLAG_RST 1'b0
`define IOMB_ZERO_BYTE 8'h00
`define IOMB_ONE_BYTE 8'h01

`endif

/* design/iomb_decode.v */
`timescale 1ns/1ps
`include "iomb_defines.vh"

module iomb_decode (
  input wire [13:0] opcode,
  output reg [2:0] kind
);

  // ----------------------------------------------------------------
  // Pattern match of the supported opcodes.
  // ----------------------------------------------------------------
  always @* begin
    kind = `IOMB_K_NONE;
    if ((opcode & `IOMB_BYTE_MASK) == `IOMB_INCSKIP_PAT) begin
      kind = `IOMB_K_INCSKIP;
    end else if ((opcode & `IOMB_BYTE_MASK) == `IOMB_INC_PAT) begin
      kind = `IOMB_K_INC;
    end else if ((opcode & `IOMB_BYTE_MASK) == `IOMB_ORF_PAT) begin
      kind = `IOMB_K_IORF;
    end else if ((opcode & `IOMB_BYTE_MASK) == `IOMB_MOVE_PAT) begin
      kind = `IOMB_K_MOVE;
    end else if ((opcode & `IOMB_IORL_MASK) == `IOMB_IORL_PAT) begin
      kind = `IOMB_K_IORL;
    end else if ((opcode & `IOMB_BR_MASK) == `IOMB_BR_PAT) begin
      kind = `IOMB_K_BRANCH;
    end
  end

endmodule

/* design/iomb_exec.v */
`timescale 1ns/1ps
`include "iomb_defines.vh"

module iomb_exec (
  input wire clk,
  input wire rst,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire [7:0] file_rdata,
  input wire [7:0] upper_page_latch,
  output reg [6:0] file_addr_r,
  output reg [7:0] file_wdata_r,
  output reg file_we_r,
  output reg [7:0] acc_r,
  output reg zero_flag_r,
  output reg [12:0] program_counter_r,
  output reg branch_load_r,
  output reg squash_r,
  output reg busy_r
);

  // ----------------------------------------------------------------
  // Decode and operand extraction.
  // ----------------------------------------------------------------
  wire [2:0] kind;
  wire [6:0] faddr;
  wire dest;
  wire [7:0] lit;
  wire [10:0] br_imm;
  reg [7:0] result;
  reg upd_zero;
  reg to_file;
  reg to_acc;

  iomb_decode u_dec (
    .opcode(instr),
    .kind(kind)
  );

  // The address is 7 bits wide, so registers 0 through 127 are reached.
  assign faddr = instr[`IOMB_FA_W-1:0];
  assign dest = instr[`IOMB_DEST_BIT];
  assign lit = instr[`IOMB_LIT_MSB:0];
  assign br_imm = instr[`IOMB_BR_MSB:0];

  // ----------------------------------------------------------------
  // Result path and destination select.
  // ----------------------------------------------------------------
  // The file register data is expected valid in the same cycle as the
  // instruction; the fetch stage presents the address ahead of time.
  always @* begin
    result = `IOMB_ZERO_BYTE;
    upd_zero = 1'b0;
    to_file = 1'b0;
    to_acc = 1'b0;
    case (kind)
      `IOMB_K_INCSKIP: begin
        result = file_rdata + `IOMB_ONE_BYTE;
        to_file = dest;
        to_acc = ~dest;
      end
      `IOMB_K_INC: begin
        result = file_rdata + `IOMB_ONE_BYTE;
        upd_zero = 1'b1;
        to_file = dest;
        to_acc = ~dest;
      end
      `IOMB_K_IORL: begin
        result = acc_r | lit;
        upd_zero = 1'b1;
        to_acc = 1'b1;
      end
      `IOMB_K_IORF: begin
        result = acc_r | file_rdata;
        upd_zero = 1'b1;
        to_file = dest;
        to_acc = ~dest;
      end
      `IOMB_K_MOVE: begin
        // With dest set this rewrites the register unchanged, a zero test.
        result = file_rdata;
        upd_zero = 1'b1;
        to_file = dest;
        to_acc = ~dest;
      end
      default: begin
        result = `IOMB_ZERO_BYTE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Issue control.
  // ----------------------------------------------------------------
  // A slot is taken only when the previous instruction has not claimed
  // it. The claimed slot is the no-operation of a taken skip or the
  // second cycle of a branch; its opcode is dropped unseen.
  wire exec_en;
  wire shadow_hit;
  wire result_zero;
  wire skip_taken;
  wire branch_taken;

  assign exec_en = instr_valid & ~busy_r;
  assign shadow_hit = instr_valid & busy_r;
  // One zero test of the 8-bit result serves every flag update.
  assign result_zero = (result == `IOMB_ZERO_BYTE);
  // Only the skipping increment may squash, and only on a wrap to zero.
  assign skip_taken = exec_en & (kind == `IOMB_K_INCSKIP) &
    result_zero;
  assign branch_taken = exec_en & (kind == `IOMB_K_BRANCH);

  // ----------------------------------------------------------------
  // Slot sequencing.
  // ----------------------------------------------------------------
  // Two states: run executes the offered slot, shadow spends the one
  // slot that a taken skip or a branch claims. The state register is the
  // busy output itself, so the fetch stage sees it with no extra delay.
  localparam SLOT_RUN = 1'b0;
  localparam SLOT_SHADOW = 1'b1;

  reg busy_nxt;

  always @* begin
    busy_nxt = busy_r;
    case (busy_r)
      SLOT_RUN: begin
        if (skip_taken || branch_taken) begin
          busy_nxt = SLOT_SHADOW;
        end
      end
      SLOT_SHADOW: begin
        // An empty cycle keeps waiting; the next valid slot is the one
        // that is consumed, whatever it holds.
        if (shadow_hit) begin
          busy_nxt = SLOT_RUN;
        end
      end
      default: begin
        busy_nxt = SLOT_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next values of the datapath outputs.
  // ----------------------------------------------------------------
  // Strobes default low so that each lasts exactly one cycle; the held
  // values keep their contents until the next executed slot.
  reg [6:0] file_addr_nxt;
  reg [7:0] file_wdata_nxt;
  reg file_we_nxt;
  reg [7:0] acc_nxt;
  reg zero_flag_nxt;
  reg [12:0] program_counter_nxt;
  reg branch_load_nxt;
  reg squash_nxt;

  always @* begin
    file_addr_nxt = file_addr_r;
    file_wdata_nxt = file_wdata_r;
    file_we_nxt = 1'b0;
    acc_nxt = acc_r;
    zero_flag_nxt = zero_flag_r;
    program_counter_nxt = program_counter_r;
    branch_load_nxt = 1'b0;
    squash_nxt = 1'b0;
    // Address and data follow every executed slot, even one that does
    // not write; only the strobe qualifies them.
    if (exec_en) begin
      file_addr_nxt = faddr;
      file_wdata_nxt = result;
      file_we_nxt = to_file;
      if (to_acc) begin
        acc_nxt = result;
      end
      if (upd_zero) begin
        zero_flag_nxt = result_zero;
      end
    end
    // A skip that wraps keeps the status bits; the result still lands.
    if (skip_taken) begin
      squash_nxt = 1'b1;
    end
    if (branch_taken) begin
      // Flags and the accumulator are left alone; the counter is loaded.
      program_counter_nxt = {upper_page_latch[`IOMB_PAGE_HI:
        `IOMB_PAGE_LO], br_imm};
      branch_load_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  // Every output is a flip-flop. The write lands one cycle after the
  // instruction, so the datapath has to forward a pending write to a
  // read of the same register in the next slot.
  // Reset clears every strobe, so nothing is written before a slot.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      file_addr_r <= `IOMB_FA_RST;
      file_wdata_r <= `IOMB_ZERO_BYTE;
      file_we_r <= 1'b0;
      acc_r <= `IOMB_ACC_RST;
      zero_flag_r <= `IOMB_ZERO_FLAG_RST;
      program_counter_r <= `IOMB_TARGET_RST;
      branch_load_r <= 1'b0;
      squash_r <= 1'b0;
      busy_r <= SLOT_RUN;
    end else begin
      file_addr_r <= file_addr_nxt;
      file_wdata_r <= file_wdata_nxt;
      file_we_r <= file_we_nxt;
      acc_r <= acc_nxt;
      zero_flag_r <= zero_flag_nxt;
      program_counter_r <= program_counter_nxt;
      branch_load_r <= branch_load_nxt;
      squash_r <= squash_nxt;
      busy_r <= busy_nxt;
    end
  end

endmodule

/* sim/iomb_fmem.sv */
`timescale 1ns/1ps
// File register datapath; the read follows the opcode's address field.
module iomb_fmem (
  input logic clk,
  input logic [13:0] instr,
  input logic [6:0] file_addr_r,
  input logic [7:0] file_wdata_r,
  input logic file_we_r,
  output logic [7:0] file_rdata
);
  logic [7:0] m [0:127];
  // Descending fill so that register 0 holds 8'hFF for the wrap cases.
  initial for (int i = 0; i < 128; i++) m[i] = 8'(8'hFF - i);
  // Write-first: a write still in flight is forwarded to the next read.
  assign file_rdata = (file_we_r && file_addr_r == instr[6:0]) ?
    file_wdata_r : m[instr[6:0]];
  // Only the strobe writes, so a stuck strobe shows up as corruption.
  always @(posedge clk) if (file_we_r) m[file_addr_r] <= file_wdata_r;
endmodule

/* sim/iomb_exec_props.sv */
`timescale 1ns/1ps
module iomb_exec_props (
  input logic clk,
  input logic rst,
  input logic instr_valid,
  input logic [13:0] instr,
  input logic [7:0] file_rdata,
  input logic [7:0] upper_page_latch,
  input logic [7:0] file_wdata_r,
  input logic [7:0] acc_r,
  input logic [6:0] file_addr_r,
  input logic file_we_r,
  input logic zero_flag_r,
  input logic branch_load_r,
  input logic squash_r,
  input logic busy_r,
  input logic [12:0] program_counter_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Own decode of a taken slot, kept apart from the design's decoder.
  wire t = instr_valid & !busy_r;
  wire [5:0] o = instr[13:8];
  wire inc = t & o == 6'h0A;
  wire sk = t & o == 6'h0F;
  wire mv = t & o == 6'h08;
  wire br = t & instr[13:11] == 3'h5;
  wire d = instr[7];
  AST_INC: assert property (inc & d |=> file_we_r &&
    file_wdata_r == 8'($past(file_rdata) + 8'h01)) else $error("inc");
  AST_SKZ: assert property (sk & file_rdata == 8'hFF |=>
    squash_r && busy_r && $stable(zero_flag_r)) else $error("skip");
  AST_DST: assert property (mv & !d |=> !file_we_r &&
    acc_r == $past(file_rdata)) else $error("dest");
  AST_TGT: assert property (br |=> branch_load_r &&
    program_counter_r == {$past(upper_page_latch[4:3]),
    $past(instr[10:0])}) else $error("target");
  AST_BR: assert property (br |=> busy_r && $stable(zero_flag_r))
    else $error("br");
  AST_ORL: assert property (t & o == 6'h38 |=> acc_r ==
    ($past(acc_r) | $past(instr[7:0]))) else $error("orl");
  AST_ORF: assert property (t & o == 6'h04 & d |=>
    file_wdata_r == ($past(acc_r) | $past(file_rdata))) else $error("orf");
  AST_MVZ: assert property (mv |=>
    zero_flag_r == ($past(file_rdata) == 8'h00)) else $error("zero");
  AST_SHD: assert property (instr_valid & busy_r |=> !file_we_r &&
    !squash_r && !busy_r && $stable(acc_r)) else $error("shadow");
  AST_ADR: assert property (inc & d |=>
    file_addr_r == $past(instr[6:0])) else $error("addr");
  cover property (br);
  cover property (sk & file_rdata == 8'hFF);
  cover property (mv & d);
endmodule
bind iomb_exec iomb_exec_props iomb_exec_props_i (.*);

/* sim/tb.sv */
`timescale 1ns/1ps
`define CK(n, e, s) begin checks_done++; if ((e) !== (s)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
  logic clk = 0, rst = 1, instr_valid = 0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] upper_page_latch = 8'h00, file_rdata, file_wdata_r, acc_r;
  logic [6:0] file_addr_r;
  logic file_we_r, zero_flag_r, branch_load_r, squash_r, busy_r;
  logic [12:0] program_counter_r;
  logic [39:0] q [$];
  logic [39:0] e = 40'h0;
  logic [39:0] x;
  int errors = 0, checks_done = 0, cyc = 0;
  iomb_exec iomb_exec_i (.*);
  iomb_fmem iomb_fmem_i (.*);
  initial forever #20 clk = ~clk;
  // Hang guard.
  always @(posedge clk) if (++cyc == 1000) begin errors++; stop_test(); end
  // One note per valid slot, compared once the edge's updates land.
  wire [11:0] st = {acc_r, zero_flag_r, file_we_r, branch_load_r, squash_r};
  always @(posedge clk) if (instr_valid) begin
    #2 x = q.pop_front();
    `CK("state", x[32:21], st)
    `CK("busy", x[22] | x[21], busy_r)
    if (x[23]) `CK("wdata", x[20:13], file_wdata_r)
    if (x[23]) `CK("addr", x[39:33], file_addr_r)
    if (x[22]) `CK("target", x[12:0], program_counter_r)
  end
  // Issue one opcode; a taken skip or a branch eats a junk slot that must drop.
  task automatic ex(input logic [13:0] op);
    logic [7:0] r, s;
    // A write from the slot before lands only at this slot's edge.
    r = e[23] && e[39:33] == op[6:0] ? e[20:13] : iomb_fmem_i.m[op[6:0]];
    s = op[13:8] == 6'h04 ? e[32:25] | r : op[13:8] == 6'h08 ? r : r + 8'h01;
    e[23:21] = 3'h0;
    if (op[13:11] == 3'h5) begin
      e[22] = 1'b1;
      e[12:0] = {upper_page_latch[4:3], op[10:0]};
    end else if (op[13:8] == 6'h38) begin
      e[32:25] = e[32:25] | op[7:0];
      e[24] = e[32:25] == 8'h00;
    end else begin
      if (op[13:8] == 6'h0F) e[21] = s == 8'h00;
      else e[24] = s == 8'h00;
      if (op[7]) begin
        e[23] = 1'b1;
        e[20:13] = s;
        e[39:33] = op[6:0];
      end else begin
        e[32:25] = s;
      end
    end
    instr = op;
    instr_valid = 1'b1;
    q.push_back(e);
    @(posedge clk) #1;
    if (e[22:21] != 2'b00) begin
      instr = 14'h38FF;
      e[23:21] = 3'h0;
      q.push_back(e);
      @(posedge clk) #1;
    end
  endtask
  task automatic fin(input int n);
    instr_valid = 1'b0;
    @(posedge clk) #1;
    $display("test %0d done", n);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7F90));
    repeat (2) @(posedge clk);
    #1 rst = 0;
    ex(14'h3800);
    repeat (4) ex({6'h38, 8'($urandom)});
    fin(1);
    ex(14'h0A80);
    ex(14'h0800);
    ex(14'h0A02);
    ex(14'h0881);
    fin(2);
    ex(14'h0A81);
    ex(14'h0F81);
    ex(14'h0F02);
    fin(3);
    repeat (3) begin
      upper_page_latch = 8'($urandom);
      ex({3'h5, 11'($urandom)});
    end
    fin(4);
    ex(14'h0403);
    ex(14'h0483);
    fin(5);
    stop_test();
  end
endmodule
